// >>> hdl/rtcsp_pkg.sv
// constants and types shared by the rtc serial register port
// Summary of operation
// (RULE_01) four-wire: select low opens a transfer; while high inputs ignored, output released
// (RULE_02) four-wire: sample on strobe edge, drive on shift edge, chosen by clock polarity
// (RULE_03) one serial clock per bit; address and data come in eight-bit bytes
// (RULE_04) four-wire: bytes move most significant bit first in and out
// (RULE_05) first byte is address; top bit zero means reads, one means writes
// (RULE_06) pointer advances after every data byte while the transfer stays open; here a write byte refused by a full buffer leaves it unchanged
// (RULE_07) read pointer wraps 0Fh to 00h, write pointer wraps 8Fh to 80h
// (RULE_08) four-wire: time copy taken only when select falls
// (RULE_09) four-wire read: output undriven until a full data byte is ready
// (RULE_10) host makes the serial clock and toggles it only during bits
// (RULE_11) three-wire: enable high opens a transfer; one shared two-way data line
// (RULE_12) three-wire: sample on rising clock, drive on falling clock
// (RULE_13) three-wire: bytes move least significant bit first both ways
// (RULE_14) three-wire: time copy taken only when enable rises
// (RULE_15) single-byte access is address plus exactly one data byte
// (RULE_16) power-fail condition blocks every serial read and write
// (RULE_17) pushbutton debounce drives reset low and inhibits serial access
// (RULE_18) low seven address bits start the pointer; partial bytes never commit
package rtcsp_pkg;
  localparam int          RTCSP_BYTE_BITS   = 8;
  localparam logic [2:0]  RTCSP_BIT_LAST    = 3'h7;
  localparam logic [6:0]  RTCSP_PTR_RST     = 7'h00;
  localparam logic [6:0]  RTCSP_RD_WRAP_HI  = 7'h0F;
  localparam logic [6:0]  RTCSP_RD_WRAP_LO  = 7'h00;
  localparam logic [6:0]  RTCSP_WR_WRAP_HI  = 7'h0F;
  localparam logic [6:0]  RTCSP_WR_WRAP_LO  = 7'h00;
  localparam int          RTCSP_TIME_REGS   = 8;
  localparam logic [7:0]  RTCSP_REG_RST     = 8'h00;
  localparam int          RTCSP_BUF_DEPTH   = 2;
  typedef enum logic [1:0] {RTCSP_IDLE, RTCSP_ADDR, RTCSP_DATA} rtcsp_state_t;
endpackage

// >>> hdl/rtcsp_buf.sv
// two-entry valid/ready buffer for write words
`timescale 1ns/1ns
module rtcsp_buf
  import rtcsp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [14:0] in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [14:0]      out_data
);
  logic [14:0] mem_q [RTCSP_BUF_DEPTH];
  logic        wp_q;
  logic        rp_q;
  logic [1:0]  cnt_q;
  wire         push = in_valid && in_ready;
  wire         pop  = out_valid && out_ready;

  // flags and head word
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];

  // pointers and fill count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage
  always_ff @(posedge core_clk) begin
    if (push) mem_q[wp_q] <= in_data;
  end
endmodule

// >>> hdl/rtcsp_port.sv
// serial register port top: four-wire and three-wire variants
`timescale 1ns/1ns
module rtcsp_port
  import rtcsp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        three_wire,
  input  wire logic        cpol,
  input  wire logic        select_low_in,
  input  wire logic        enable_in,
  input  wire logic        sclk_in,
  input  wire logic        sdi_in,
  input  wire logic        sio_in,
  output logic             sdo_out,
  output logic             sdo_oe,
  output logic             sio_out,
  output logic             sio_oe,
  input  wire logic        power_fail,
  input  wire logic        pb_debounce,
  output logic             rst_n_out,
  input  wire logic [63:0] live_time,
  input  wire logic [7:0]  reg_rd_data,
  output logic [6:0]       reg_rd_addr,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [6:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic             snap_pulse,
  output logic [63:0]      snap_time
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [2:0] sck_s_q, sel_s_q, en_s_q, di_s_q, io_s_q;
  // three flops each, second and third compared
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sck_s_q <= 3'h0;
      sel_s_q <= 3'h7;
      en_s_q  <= 3'h0;
      di_s_q  <= 3'h0;
      io_s_q  <= 3'h0;
    end else begin
      sck_s_q <= {sck_s_q[1:0], sclk_in};
      sel_s_q <= {sel_s_q[1:0], select_low_in};
      en_s_q  <= {en_s_q[1:0], enable_in};
      di_s_q  <= {di_s_q[1:0], sdi_in};
      io_s_q  <= {io_s_q[1:0], sio_in};
    end
  end

  // qualified edges and levels
  wire sck_rise = sck_s_q[1] && !sck_s_q[2];
  wire sck_fall = !sck_s_q[1] && sck_s_q[2];
  wire open_lvl = three_wire ? en_s_q[2] : !sel_s_q[2];
  wire open_now = three_wire ? en_s_q[1] : !sel_s_q[1];
  wire start_ev = open_now && !open_lvl;              // [RULE_08] [RULE_14]
  wire blocked  = power_fail || pb_debounce;          // [RULE_16] [RULE_17]
  wire sample_e = three_wire ? sck_rise : (cpol ? sck_rise : sck_fall); // [RULE_02] [RULE_12]
  wire shift_e  = three_wire ? sck_fall : (cpol ? sck_fall : sck_rise); // [RULE_02] [RULE_12]
  wire bit_in   = three_wire ? io_s_q[2] : di_s_q[2];

  // ****************************************
  // transfer state
  // ****************************************
  rtcsp_state_t st_q, st_d;
  logic [2:0]   cnt_q;
  logic [7:0]   sh_q;
  logic [6:0]   ptr_q;
  logic         wr_q;
  logic [7:0]   tx_q;
  logic         drv_q;
  logic [63:0]  snap_q;
  logic         rst_q;
  logic         snp_q;
  logic         ld_q;

  // assembled byte: msb first shifts left, lsb first shifts right
  wire [7:0] sh_next = three_wire ? {bit_in, sh_q[7:1]} : {sh_q[6:0], bit_in}; // [RULE_04] [RULE_13]
  wire       byte_done = sample_e && (cnt_q == RTCSP_BIT_LAST);  // [RULE_03]
  wire       active    = open_lvl && open_now && !blocked;

  // pointer advance with wrap, separate for reads and writes
  function automatic logic [6:0] ptr_inc(input logic [6:0] p, input logic w);
    logic [6:0] hi;
    logic [6:0] lo;
    hi = w ? RTCSP_WR_WRAP_HI : RTCSP_RD_WRAP_HI;
    lo = w ? RTCSP_WR_WRAP_LO : RTCSP_RD_WRAP_LO;
    ptr_inc = (p == hi) ? lo : p + 7'h01;
  endfunction

  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      RTCSP_IDLE: if (start_ev && !blocked) st_d = RTCSP_ADDR;
      RTCSP_ADDR: if (!active) st_d = RTCSP_IDLE;
                  else if (byte_done) st_d = RTCSP_DATA;  // [RULE_05]
      RTCSP_DATA: if (!active) st_d = RTCSP_IDLE;
      default:    st_d = RTCSP_IDLE;
    endcase
  end

  wire buf_ready;
  wire wr_push = (st_q == RTCSP_DATA) && active && byte_done && wr_q; // [RULE_18]
  wire rd_byte = (st_q == RTCSP_DATA) && active && byte_done && !wr_q;
  wire adr_byte = (st_q == RTCSP_ADDR) && active && byte_done;
  wire [7:0] rd_bits = (ptr_q < 7'(RTCSP_TIME_REGS)) ? snap_q[ptr_q[2:0]*8 +: 8] : reg_rd_data;

  // serial datapath
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q  <= RTCSP_IDLE;
      cnt_q <= 3'h0;
      sh_q  <= RTCSP_REG_RST;
      ptr_q <= RTCSP_PTR_RST;
      wr_q  <= 1'b0;
      tx_q  <= RTCSP_REG_RST;
      drv_q <= 1'b0;
      ld_q  <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_d == RTCSP_IDLE || start_ev) begin
        cnt_q <= 3'h0;                                    // [RULE_18]
        drv_q <= 1'b0;                                    // [RULE_01] [RULE_09]
      end else if (sample_e) begin
        cnt_q <= cnt_q + 3'h1;
        sh_q  <= sh_next;
      end
      if (adr_byte) begin
        wr_q  <= sh_next[7];                              // [RULE_05]
        ptr_q <= sh_next[6:0];                            // [RULE_18]
      end else if ((wr_push && buf_ready) || rd_byte) begin
        ptr_q <= ptr_inc(ptr_q, wr_q);                    // [RULE_06] [RULE_07]
      end
      // reload one cycle after a read byte, once pointer and register data have moved on
      ld_q <= rd_byte;
      // load a whole byte before driving, then shift on the shift edge
      if (st_q == RTCSP_DATA && !wr_q && active && cnt_q == 3'h0 && !drv_q) begin
        tx_q  <= rd_bits;
        drv_q <= 1'b1;                                    // [RULE_09]
      end else if (drv_q && shift_e && cnt_q != 3'h0) begin
        tx_q  <= three_wire ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
      end else if (drv_q && ld_q) begin
        tx_q  <= rd_bits;                                 // [RULE_06]
      end
    end
  end

  // snapshot, reset pin and output pins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      snap_q  <= 64'h0;
      rst_q   <= 1'b0;
      snp_q   <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe  <= 1'b0;
      sio_out <= 1'b0;
      sio_oe  <= 1'b0;
    end else begin
      if (start_ev) snap_q <= live_time;                  // [RULE_08] [RULE_14]
      snp_q   <= start_ev;
      rst_q   <= !(power_fail || pb_debounce);            // [RULE_17]
      sdo_out <= three_wire ? 1'b0 : tx_q[7];             // [RULE_04]
      sdo_oe  <= !three_wire && drv_q && active;          // [RULE_01] [RULE_09]
      sio_out <= three_wire ? tx_q[0] : 1'b0;             // [RULE_13]
      sio_oe  <= three_wire && drv_q && active;           // [RULE_11]
    end
  end

  assign reg_rd_addr = ptr_q;
  assign snap_time   = snap_q;
  assign snap_pulse  = snp_q;
  assign rst_n_out   = rst_q;

  // ****************************************
  // write buffer
  // ****************************************
  rtcsp_buf u_buf (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_valid  (wr_push),
    .in_ready  (buf_ready),
    .in_data   ({ptr_q, sh_next}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_idle_no_drive: assert property (!open_lvl |=> !sdo_oe && !sio_oe) // [RULE_01]
    else $error("output driven while closed");
  // protocol checks
  a_block_no_wr: assert property (blocked |-> !wr_push ##1 (st_q == RTCSP_IDLE)) // [RULE_16]
    else $error("write accepted while blocked");
  a_addr_no_drive: assert property (st_q == RTCSP_ADDR |=> !sdo_oe) // [RULE_09]
    else $error("output driven during address");
  a_snap_hold: assert property (!start_ev |=> $stable(snap_q)) // [RULE_08]
    else $error("snapshot moved mid transfer");
  a_rd_wrap: assert property (rd_byte && ptr_q == RTCSP_RD_WRAP_HI |=> ptr_q == RTCSP_RD_WRAP_LO) // [RULE_07]
    else $error("read wrap wrong");
  a_ptr_step: assert property (rd_byte && ptr_q != RTCSP_RD_WRAP_HI |=> ptr_q == $past(ptr_q) + 7'h01) // [RULE_06]
    else $error("pointer not advanced");
  a_close_idle: assert property (!open_now |-> ##[1:2] st_q == RTCSP_IDLE) // [RULE_18]
    else $error("closed transfer not idle");
  a_rst_pin: assert property (pb_debounce |=> !rst_n_out) // [RULE_17]
    else $error("reset pin not low");
  a_wr_wrap: assert property (wr_push && buf_ready && ptr_q == RTCSP_WR_WRAP_HI // [RULE_07]
                              |=> ptr_q == RTCSP_WR_WRAP_LO)
    else $error("write wrap wrong");
  a_snap_take: assert property (start_ev |=> snap_q == $past(live_time)) // [RULE_08]
    else $error("snapshot not taken at open");
  a_sdo_release: assert property (blocked |=> !sdo_oe && !sio_oe) // [RULE_16]
    else $error("output driven while blocked");
  // main scenarios reached
  c_write: cover property (wr_push);
  c_read: cover property (rd_byte);
  c_wrap: cover property (rd_byte && ptr_q == RTCSP_RD_WRAP_HI);
  c_three_rd: cover property (three_wire && rd_byte);
  c_blocked_open: cover property (blocked && start_ev);
endmodule

// >>> tb/rtcsp_host.sv
// host master model that clocks the serial port pins
`timescale 1ns/1ns
module rtcsp_host (
  output logic      sclk,
  output logic      sel_n,
  output logic      en,
  output logic      sdi,
  output logic      h_sio,
  output logic      h_oe,
  input  wire logic three_wire,
  input  wire logic cpol,
  input  wire logic sdo,
  input  wire logic sio
);
  localparam int HALF = 40;
  initial begin
    sclk = 1'h0; sel_n = 1'h1; en = 1'h0; sdi = 1'h0; h_sio = 1'h0; h_oe = 1'h0;
  end
  // open: clock rests at idle level, then select
  task automatic open_x();
    sclk = three_wire ? 1'h0 : cpol;
    #(HALF);
    if (three_wire) en = 1'h1; else sel_n = 1'h0;
    #(2*HALF);
  endtask
  // close: released lines flip so no stale bit is seen
  task automatic close_x();
    #(HALF);
    sel_n = 1'h1; en = 1'h0; h_oe = 1'h0;
    sdi = ~sdi; h_sio = ~h_sio;
    #(2*HALF);
  endtask
  // one whole byte, msb first four-wire, lsb first three-wire
  task automatic xfer(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    int k;
    h_oe = drv & three_wire;
    for (k = 0; k < 8; k++) begin
      sdi = three_wire ? tx[k] : tx[7-k];
      h_sio = sdi;
      if (three_wire) begin
        #(HALF); rx[k] = sio; sclk = 1'h1; #(HALF); sclk = 1'h0;
      end else begin
        sclk = ~sclk; #(HALF); rx[7-k] = sdo; sclk = ~sclk; #(HALF);
      end
    end
  endtask
endmodule

// >>> tb/rtcsp_port_tb.sv
// self-checking testbench for the rtc serial register port
`timescale 1ns/1ns
module rtcsp_port_tb;
  import rtcsp_pkg::*;
  logic core_clk = 1'h0, resetn = 1'h0, three_wire = 1'h0, cpol = 1'h1;
  logic power_fail = 1'h0, pb_debounce = 1'h0, wr_ready = 1'h1;
  logic [63:0] live_time = 64'h0123456789ABCDEF;
  logic [63:0] lt;
  logic [7:0] rx;
  wire sclk, sel_n, en, sdi, h_sio, h_oe, sdo_out, sdo_oe, sio_out, sio_oe, rst_n_out, wr_valid, snap_pulse;
  wire [6:0] reg_rd_addr, wr_addr;
  wire [7:0] wr_data;
  wire [63:0] snap_time;
  wire [7:0] reg_rd_data = {1'h0, reg_rd_addr} ^ 8'h5A;
  wire sdo_w = sdo_oe ? sdo_out : ~sdi;
  wire sio_w = sio_oe ? sio_out : (h_oe ? h_sio : ~h_sio);
  int n_fail = 0, cmp_count = 0;
  int n_snap = 0;
  logic [14:0] wq[$];
  always #4 core_clk = ~core_clk;
  // collect accepted write words
  always @(posedge core_clk) if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
  // count snapshot pulses
  always @(posedge core_clk) if (snap_pulse) n_snap++;
  rtcsp_host rtcsp_host_inst (.sclk(sclk), .sel_n(sel_n), .en(en), .sdi(sdi), .h_sio(h_sio), .h_oe(h_oe),
    .three_wire(three_wire), .cpol(cpol), .sdo(sdo_w), .sio(sio_w));
  rtcsp_port rtcsp_port_inst (.core_clk(core_clk), .resetn(resetn), .three_wire(three_wire), .cpol(cpol),
    .select_low_in(sel_n), .enable_in(en), .sclk_in(sclk), .sdi_in(sdi), .sio_in(sio_w), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .sio_out(sio_out), .sio_oe(sio_oe), .power_fail(power_fail), .pb_debounce(pb_debounce),
    .rst_n_out(rst_n_out), .live_time(live_time), .reg_rd_data(reg_rd_data), .reg_rd_addr(reg_rd_addr),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .snap_pulse(snap_pulse),
    .snap_time(snap_time));
  // ****************************************
  // compare and report tasks
  // ****************************************
  task automatic results();
    $display("compares %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait for the next write word
  task automatic chk_wr(input logic [14:0] exp);
    int i;
    for (i = 0; i < 300 && wq.size() == 0; i++) @(posedge core_clk);
    if (wq.size() == 0) begin
      chk(16'hFFFF, {1'h0, exp});
      results();
    end else chk({1'h0, wq.pop_front()}, {1'h0, exp});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_wr4();
    @(negedge core_clk) begin cpol = 1'h1; three_wire = 1'h0; wr_ready = 1'h0; end
    rtcsp_host_inst.open_x();
    rtcsp_host_inst.xfer(8'h8F, 1'h1, rx);
    rtcsp_host_inst.xfer(8'hA1, 1'h1, rx);
    rtcsp_host_inst.xfer(8'hB2, 1'h1, rx);
    rtcsp_host_inst.close_x();
    chk(16'(wq.size()), 16'h0000); // stalled words held
    @(negedge core_clk) wr_ready = 1'h1;
    chk_wr({7'h0F, 8'hA1});
    chk_wr({7'h00, 8'hB2});
  endtask
  task automatic s_rd4();
    int ns;
    @(negedge core_clk) cpol = 1'h0;
    lt = live_time;
    ns = n_snap;
    rtcsp_host_inst.open_x();
    @(negedge core_clk) live_time = ~live_time;
    chk(16'(n_snap - ns), 16'h0001); // one snapshot per open
    chk(snap_time[15:0], lt[15:0]);
    rtcsp_host_inst.xfer(8'h0E, 1'h1, rx);
    rtcsp_host_inst.xfer(8'h00, 1'h0, rx);
    chk({8'h00, rx}, 16'h0054);
    rtcsp_host_inst.xfer(8'h00, 1'h0, rx);
    chk({8'h00, rx}, 16'h0055);
    rtcsp_host_inst.xfer(8'h00, 1'h0, rx);
    chk({8'h00, rx}, {8'h00, lt[7:0]});
    rtcsp_host_inst.close_x();
    chk({15'h0000, sdo_oe}, 16'h0000);
  endtask
  task automatic s_wr3();
    @(negedge core_clk) three_wire = 1'h1;
    rtcsp_host_inst.open_x();
    rtcsp_host_inst.xfer(8'h83, 1'h1, rx);
    rtcsp_host_inst.xfer(8'hA6, 1'h1, rx); // single byte then close
    rtcsp_host_inst.close_x();
    chk_wr({7'h03, 8'hA6});
  endtask
  task automatic s_rd3();
    @(negedge core_clk) lt = live_time;
    rtcsp_host_inst.open_x();
    @(negedge core_clk) live_time = ~live_time;
    chk(snap_time[31:16], lt[31:16]);
    rtcsp_host_inst.xfer(8'h02, 1'h1, rx);
    rtcsp_host_inst.xfer(8'h00, 1'h0, rx);
    rtcsp_host_inst.close_x();
    chk({8'h00, rx}, {8'h00, lt[23:16]});
    chk({15'h0000, sio_oe}, 16'h0000);
  endtask
  task automatic s_block(input logic pf);
    @(negedge core_clk) begin three_wire = 1'h0; cpol = 1'h1; power_fail = pf; pb_debounce = ~pf; end
    repeat (10) @(negedge core_clk);
    chk({15'h0000, rst_n_out}, 16'h0000);
    rtcsp_host_inst.open_x();
    rtcsp_host_inst.xfer(8'h83, 1'h1, rx);
    rtcsp_host_inst.xfer(8'h11, 1'h1, rx);
    rtcsp_host_inst.close_x();
    @(negedge core_clk) begin power_fail = 1'h0; pb_debounce = 1'h0; end
    repeat (40) @(negedge core_clk);
    chk(16'(wq.size()), 16'h0000);
    chk({15'h0000, rst_n_out}, 16'h0001);
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) resetn = 1'h1;
    repeat (4) @(negedge core_clk);
    s_wr4();
    s_rd4();
    s_wr3();
    s_rd3();
    s_block(1'h1);
    s_block(1'h0);
    results();
  end
endmodule
